//--- verification/lpws_seq_monitor.sv
// Checker for the wakeup sequencer: order and timing of recovery seen at the ports.
// Assumes it is bound into lpws_seq and sees only that module's ports.
`timescale 1ns/1ns
module lpws_seq_monitor
	import lpws_pkg::*;
#(
	parameter int MVR_CYC = MVR_WAKE_CYC    // Regulator wait, as set on the design
)(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       halt_req,
	input wire logic       wait_req,
	input wire logic       wake_pin,
	input wire logic       cpu_run,
	input wire logic       vec_fetch,
	input wire logic       mvr_en,
	input wire logic       hsi_en,
	input wire logic       xtal_en,
	input wire logic       flash_pd,
	input wire logic [1:0] clk_sel,
	input wire logic [7:0] periph_clk_en,
	input wire logic [7:0] periph_pwr_en
);
	logic        mvr_seen;   // Regulator restarted in this wakeup
	logic [15:0] mvr_cnt;    // Cycles since the restart
	logic        fl_seen;    // Flash powered up in this wakeup
	logic [15:0] fl_cnt;     // Cycles since flash power-up
	logic        in_wait;    // CPU parked in wait mode

	default clocking mon_cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Regulator recovery time; saturates so a long halt cannot wrap it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mvr_seen <= 1'b0;
			mvr_cnt  <= 16'h0000;
		end else if ($rose(mvr_en)) begin
			mvr_seen <= 1'b1;
			mvr_cnt  <= 16'h0000;
		end else if (vec_fetch)
			mvr_seen <= 1'b0;
		else if (mvr_cnt != 16'hffff)
			mvr_cnt <= mvr_cnt + 16'h0001;
	end

	// Flash recovery time, counted from the power-down release
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fl_seen <= 1'b0;
			fl_cnt  <= 16'h0000;
		end else if ($fell(flash_pd)) begin
			fl_seen <= 1'b1;
			fl_cnt  <= 16'h0000;
		end else if (vec_fetch)
			fl_seen <= 1'b0;
		else if (fl_cnt != 16'hffff)
			fl_cnt <= fl_cnt + 16'h0001;
	end

	// Wait mode entered; halt wins when both requests come together
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			in_wait <= 1'b0;
		else if (cpu_run && !vec_fetch && wait_req && !halt_req)
			in_wait <= 1'b1;
		else if (vec_fetch)
			in_wait <= 1'b0;
	end

	chk_halt_entry: assert property (cpu_run && !vec_fetch && halt_req |=>
		!cpu_run && !hsi_en && !xtal_en) else $error("halt entry wrong");
	chk_vec_edge: assert property (vec_fetch |-> cpu_run && !$past(cpu_run))
		else $error("vector fetch without run release");
	chk_run_vec: assert property ($rose(cpu_run) |-> vec_fetch)
		else $error("run released without vector fetch");
	chk_vec_pulse: assert property (vec_fetch |=> !vec_fetch)
		else $error("vector fetch longer than one cycle");
	chk_ready_state: assert property (vec_fetch |-> mvr_en && !flash_pd &&
		(clk_sel != SRC_HSE || xtal_en) && (clk_sel != SRC_HSI || hsi_en))
		else $error("cpu released before recovery");
	chk_flash_order: assert property ($fell(flash_pd) |-> mvr_en && !cpu_run)
		else $error("flash woken before regulator");
	chk_mvr_wait: assert property (vec_fetch && mvr_seen |-> mvr_cnt >= MVR_CYC - 1)
		else $error("regulator recovery too short");
	chk_flash_wait: assert property (vec_fetch && fl_seen |->
		fl_cnt >= FLASH_WAKE_CYC - 1) else $error("flash recovery too short");
	chk_wait_wake: assert property ($rose(wake_pin) && in_wait |-> ##[2:8] vec_fetch)
		else $error("wait wakeup too slow");
	chk_reset_vals: assert property ($fell(rst) |-> periph_clk_en == PCKEN_RST &&
		periph_pwr_en == PWR_RST && cpu_run && !xtal_en) else $error("reset state wrong");

	cov_wait_wake: cover property (vec_fetch && in_wait);
	cov_flash_up: cover property (vec_fetch && fl_seen);
	cov_mvr_up: cover property (vec_fetch && mvr_seen);
endmodule

bind lpws_seq lpws_seq_monitor #(.MVR_CYC(MVR_CYC)) u_lpws_seq_monitor (
	.clk(clk), .rst(rst), .halt_req(halt_req), .wait_req(wait_req), .wake_pin(wake_pin),
	.cpu_run(cpu_run), .vec_fetch(vec_fetch), .mvr_en(mvr_en), .hsi_en(hsi_en),
	.xtal_en(xtal_en), .flash_pd(flash_pd), .clk_sel(clk_sel),
	.periph_clk_en(periph_clk_en), .periph_pwr_en(periph_pwr_en));

//--- verification/lpws_seq_test.sv
// Self-checking bench for the wakeup sequencer: register rows, then wait,
// halt, crystal, fast wakeup and reset cases. Assumes the monitor is bound in.
`timescale 1ns/1ns
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module lpws_seq_test
	import lpws_pkg::*;
;
	localparam int MVR_SIM = 20;   // Short regulator wait keeps the run brief
	typedef struct {
		logic [7:0] addr; logic [31:0] wdata; logic [3:0] strb;
		logic [1:0] bresp; logic [31:0] rdata; logic [1:0] rresp;
	} lpws_row_t;
	logic clk, rst, halt_req, active_halt, wait_req, wake_pin, xtal_clk_pin;
	logic cpu_run, vec_fetch, mvr_en, hsi_en, xtal_en, flash_pd;
	logic [1:0] clk_sel, hsi_div, s_axi_bresp, s_axi_rresp;
	logic [2:0] cpu_div;
	logic [7:0] periph_clk_en, periph_pwr_en, s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int num_errors = 0;   // Mismatches seen
	int comparisons = 0;  // Checks made
	int xcnt = 0;         // Crystal edges since the last clear
	lpws_row_t rows [8];  // Register cases

	lpws_seq #(.MVR_CYC(MVR_SIM)) u_lpws_seq (.clk(clk), .rst(rst), .halt_req(halt_req),
		.active_halt(active_halt), .wait_req(wait_req), .wake_pin(wake_pin),
		.xtal_clk_pin(xtal_clk_pin), .cpu_run(cpu_run), .vec_fetch(vec_fetch),
		.mvr_en(mvr_en), .hsi_en(hsi_en), .xtal_en(xtal_en), .flash_pd(flash_pd),
		.clk_sel(clk_sel), .cpu_div(cpu_div), .hsi_div(hsi_div),
		.periph_clk_en(periph_clk_en), .periph_pwr_en(periph_pwr_en),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

	// 125 MHz system clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Crystal runs only while enabled, out of phase with clk; stopped it sits low
	initial begin
		xtal_clk_pin = 1'b0;
		forever #13 xtal_clk_pin = (xtal_en === 1'b1) ? ~xtal_clk_pin : 1'b0;
	end
	always @(posedge xtal_clk_pin)
		xcnt++;

	// Verdict; also reached from the watchdog
	task automatic summarize;
		$display("errors %0d, comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Whole run is under two thousand cycles; this is ample
	initial begin
		#300000;
		num_errors++;
		summarize();
	end

	// Write: address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
			output logic [1:0] r);
		@(posedge clk);
		s_axi_awaddr  <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= s;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready));
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// Read: data and response taken at the handshake edge
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready));
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Halt instruction; the CPU clock and fast oscillator must stop
	task automatic halt(input logic ah);
		@(posedge clk);
		halt_req    <= 1'b1;
		active_halt <= ah;
		@(posedge clk);
		halt_req <= 1'b0;
		@(posedge clk);
		`CHK(cpu_run, 1'b0)
		`CHK(hsi_en, 1'b0)
	endtask

	// Wake edge, then cycles until the vector fetch; the pin stays up meanwhile
	task automatic wake(output int lat);
		@(posedge clk);
		wake_pin <= 1'b1;
		lat = 0;
		do begin
			@(posedge clk);
			lat++;
		end while (vec_fetch !== 1'b1 && lat < 9000);
		`CHK(cpu_run, 1'b1)
		wake_pin <= 1'b0;
	endtask

	initial begin
		logic [1:0]  r;
		logic [31:0] d;
		int          lat;
		{rst, halt_req, active_halt, wait_req, wake_pin} = 5'h10;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		rows = '{'{8'h00, 32'h3707, 4'hf, RESP_OKAY, 32'h3707, RESP_OKAY},
			'{8'h04, 32'h1234, 4'hf, RESP_OKAY, 32'h1234, RESP_OKAY},
			'{8'h04, 32'hffff_0004, 4'h1, RESP_OKAY, 32'h1204, RESP_OKAY},
			'{8'h08, 32'h00a5, 4'hf, RESP_OKAY, 32'h00a5, RESP_OKAY},
			'{8'h0c, 32'h00ff, 4'h2, RESP_OKAY, 32'h0007, RESP_OKAY},
			'{8'h10, 32'hffff, 4'hf, RESP_SLVERR, 32'h000c, RESP_OKAY},
			'{8'h14, 32'hffff, 4'hf, RESP_SLVERR, 32'h0000, RESP_SLVERR},
			'{8'h00, 32'h0000, 4'hf, RESP_OKAY, 32'h0000, RESP_OKAY}};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			axi_wr(rows[i].addr, rows[i].wdata, rows[i].strb, r);
			`CHK(r, rows[i].bresp)
			axi_rd(rows[i].addr, d, r);
			`CHK(d, rows[i].rdata)
			`CHK(r, rows[i].rresp)
		end
		`CHK(periph_clk_en, 8'ha5)
		// Every prescaler code reaches its output
		for (int i = 0; i < 8; i++) begin
			axi_wr(REG_CTRL, (32'(i) << CTRL_CDIV_LSB) | (32'(i % 4) << CTRL_HDIV_LSB), 4'hf, r);
			`CHK(cpu_div, 3'(i))
			`CHK(hsi_div, 2'(i % 4))
		end
		axi_wr(REG_CTRL, 32'h0, 4'hf, r);
		// Wait mode: wake follows within a few system clocks
		@(posedge clk);
		wait_req <= 1'b1;
		@(posedge clk);
		wait_req <= 1'b0;
		@(posedge clk);
		`CHK(cpu_run, 1'b0)
		wake(lat);
		`CHK(lat <= 10, 1'b1)
		// Plain halt skips the slow tick; active halt waits at most one tick
		halt(1'b0);
		`CHK(mvr_en, 1'b1)
		wake(lat);
		`CHK(lat <= 10, 1'b1)
		halt(1'b1);
		wake(lat);
		`CHK(lat <= LSI_TICK_CYC + 12, 1'b1)
		// Regulator and flash both off: both recovery waits must pass
		axi_wr(REG_CTRL, 32'h6, 4'hf, r);
		halt(1'b0);
		`CHK(mvr_en, 1'b0)
		`CHK(flash_pd, 1'b1)
		wake(lat);
		`CHK(lat >= MVR_SIM + FLASH_WAKE_CYC, 1'b1)
		`CHK(lat <= MVR_SIM + FLASH_WAKE_CYC + 20, 1'b1)
		// Crystal wake with a short settle count
		axi_wr(REG_SETTLE, 32'h4, 4'hf, r);
		axi_wr(REG_CTRL, 32'h10, 4'hf, r);
		`CHK(clk_sel, SRC_HSE)
		halt(1'b0);
		xcnt = 0;
		wake(lat);
		`CHK(xcnt >= 4, 1'b1)
		`CHK(clk_sel, SRC_HSE)
		// Fast wakeup ignores the long settle count and lands on the fast oscillator
		axi_wr(REG_SETTLE, 32'h800, 4'hf, r);
		axi_wr(REG_CTRL, 32'h11, 4'hf, r);
		halt(1'b0);
		wake(lat);
		`CHK(lat <= 20, 1'b1)
		`CHK(clk_sel, SRC_HSI)
		// Reset in mid-halt restores the power-on state
		axi_wr(REG_CTRL, 32'h6, 4'hf, r);
		halt(1'b0);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		`CHK(cpu_run, 1'b1)
		`CHK(periph_pwr_en, PWR_RST)
		`CHK(periph_clk_en, PCKEN_RST)
		axi_rd(REG_SETTLE, d, r);
		`CHK(d, 32'h800)
		axi_rd(REG_CTRL, d, r);
		`CHK(d, CTRL_RST)
		summarize();
	end
endmodule

//--- verilog/lpws_pkg.sv
// Constants for the low-power wakeup sequencer: register map, field
// positions, reset values, states and wakeup timing.
// Assumes a single 125 MHz system clock.
package lpws_pkg;
	// Timing figures in picoseconds, cycle counts derived at 8 ns
	localparam int CLK_PERIOD_PS  = 8000;      // 125 MHz
	localparam int LSI_PERIOD_PS  = 7812500;   // 7.8125 us wakeup-unit period
	localparam int FLASH_WAKE_PS  = 2000000;   // 2 us flash recovery
	localparam int MVR_WAKE_PS    = 50000000;  // 50 us regulator recovery
	localparam int LSI_TICK_CYC   = LSI_PERIOD_PS / CLK_PERIOD_PS;
	localparam int FLASH_WAKE_CYC = (FLASH_WAKE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int MVR_WAKE_CYC   = (MVR_WAKE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TMR_W          = 16;        // Wait timer width

	// Register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_SETTLE = 8'h04;
	localparam logic [7:0] REG_PCKEN  = 8'h08;
	localparam logic [7:0] REG_PWR    = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;

	// Control register fields
	localparam int CTRL_FAST_BIT  = 0;         // Fast clock wakeup on internal osc
	localparam int CTRL_MVR_BIT   = 1;         // Main regulator off during halt
	localparam int CTRL_FLASH_BIT = 2;         // Flash powered down during halt
	localparam int CTRL_SRC_LSB   = 4;         // Clock source, 2 bits
	localparam int CTRL_CDIV_LSB  = 8;         // CPU prescaler, 3 bits
	localparam int CTRL_HDIV_LSB  = 12;        // Internal osc prescaler, 2 bits
	localparam logic [31:0] CTRL_MASK = 32'h0000_3737;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;

	// Reset values
	localparam logic [15:0] SETTLE_RST = 16'h0800; // 2048 crystal cycles
	localparam logic [7:0]  PCKEN_RST  = 8'hff;    // All clock gates open
	localparam logic [7:0]  PWR_RST    = 8'h07;    // USART, LIN UART, debug port

	// Clock sources
	localparam logic [1:0] SRC_HSI = 2'h0;
	localparam logic [1:0] SRC_HSE = 2'h1;
	localparam logic [1:0] SRC_LSI = 2'h2;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_RUN     = 3'h0,
		ST_WAIT    = 3'h1,
		ST_HALT    = 3'h2,
		ST_MVR     = 3'h3,
		ST_OSC     = 3'h4,
		ST_FLASH   = 3'h5,
		ST_SERVICE = 3'h6
	} lpws_state_t;
endpackage

//--- verilog/lpws_seq.sv
// Wakeup sequencer top: AXI4-Lite registers, halt / wait entry and the
// ordered recovery of regulator, oscillator and flash before the CPU runs.
// Assumes wake_pin and xtal_clk_pin are asynchronous; the rest is on clk.
`timescale 1ns/1ns
// Functional notes
// - Active-halt wake sampled on slow wakeup-unit tick
// - Fast wakeup resumes on internal fast oscillator
// - Crystal wake waits programmable settle count
// - Regulator, oscillator, flash, then interrupt, in order
// - Reset: debug, UARTs powered; clock gates open
// - Powered-down flash gets 2 us recovery
// - Switched-off regulator gets 50 us recovery
// - Eight CPU and four oscillator prescaler settings
// - Plain halt skips wakeup-unit sampling delay
// - Wait-mode wake synchronised to system clock
module lpws_seq
	import lpws_pkg::*;
#(
	parameter int MVR_CYC = MVR_WAKE_CYC    // Regulator wait, shorten in sim
)(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        halt_req,
	input  wire logic        active_halt,
	input  wire logic        wait_req,
	input  wire logic        wake_pin,
	input  wire logic        xtal_clk_pin,
	output logic             cpu_run,
	output logic             vec_fetch,
	output logic             mvr_en,
	output logic             hsi_en,
	output logic             xtal_en,
	output logic             flash_pd,
	output logic [1:0]       clk_sel,
	output logic [2:0]       cpu_div,
	output logic [1:0]       hsi_div,
	output logic [7:0]       periph_clk_en,
	output logic [7:0]       periph_pwr_en,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	lpws_tmr_if tmr ();                   // Recovery timer link
	lpws_state_t state;                   // Sequencer state
	lpws_state_t next_state;              // Combinational next state
	logic [31:0] ctrl;                    // Control register
	logic [15:0] settle;                  // Crystal settle count
	logic [7:0]  aw_addr;                 // Latched write address
	logic [31:0] w_data;                  // Latched write data
	logic [3:0]  w_strb;                  // Latched byte enables
	logic        aw_got;                  // Write address held
	logic        w_got;                   // Write data held
	logic        wr_fire;                 // Write takes effect this cycle
	logic [1:0]  sync [0:2];              // Pin synchronisers, per pin a column
	logic [1:0]  pin_lvl;                 // Agreed pin levels
	logic        wake_evt;                // Debounced wake rising edge
	logic        xtal_edge;               // One crystal cycle seen
	logic [9:0]  lsi_cnt;                 // Wakeup-unit clock divider
	logic        lsi_tick;                // One slow-clock period elapsed
	logic        ah_mode;                 // Current halt is active halt
	logic        mvr_off;                 // Regulator was switched off
	logic        flash_off;               // Flash was powered down
	logic        wake_pend;               // Wake seen, awaiting sample
	logic        fast;                    // Fast wakeup selected
	logic [1:0]  src_req;                 // Software clock source
	lpws_state_t flash_step, osc_step, mvr_step;

	lpws_timer u_tmr (.clk(clk), .rst(rst), .tmr(tmr.cnt));

	assign fast    = ctrl[CTRL_FAST_BIT];
	assign src_req = ctrl[CTRL_SRC_LSB +: 2];
	assign wr_fire = aw_got && w_got && !s_axi_bvalid;

	// Three-flop synchronisers for the wake and crystal pins
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					sync[0][gi] <= 1'b0;
					sync[1][gi] <= 1'b0;
					sync[2][gi] <= 1'b0;
					pin_lvl[gi] <= 1'b0;
				end else begin
					sync[0][gi] <= (gi == 0) ? wake_pin : xtal_clk_pin;
					sync[1][gi] <= sync[0][gi];
					sync[2][gi] <= sync[1][gi];
					// A change counts only once two stages agree
					if (sync[1][gi] == sync[2][gi])
						pin_lvl[gi] <= sync[2][gi];
				end
			end
		end
	endgenerate

	assign wake_evt  = (sync[1][0] && sync[2][0] && !pin_lvl[0]);
	assign xtal_edge = (sync[1][1] && sync[2][1] && !pin_lvl[1]);

	// Slow internal oscillator period as a one-cycle enable
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lsi_cnt  <= '0;
			lsi_tick <= 1'b0;
		end else if (lsi_cnt == 10'(LSI_TICK_CYC - 1)) begin
			lsi_cnt  <= '0;
			lsi_tick <= 1'b1;
		end else begin
			lsi_cnt  <= lsi_cnt + 10'h001;
			lsi_tick <= 1'b0;
		end
	end

	// Recovery chain, later steps first so each skips what was left on
	always_comb begin
		flash_step = flash_off ? ST_FLASH : ST_SERVICE;
		osc_step   = (src_req == SRC_HSE && !fast) ? ST_OSC : flash_step;
		mvr_step   = mvr_off ? ST_MVR : osc_step;
	end

	// Next-state logic
	always_comb begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (halt_req)
					next_state = ST_HALT;
				else if (wait_req)
					next_state = ST_WAIT;
			end
			ST_WAIT: begin
				if (wake_evt)
					next_state = ST_SERVICE;
			end
			ST_HALT: begin
				// Active halt waits for the slow tick; plain halt does not
				if ((wake_pend || wake_evt) && (!ah_mode || lsi_tick))
					next_state = mvr_step;
			end
			ST_MVR: begin
				if (tmr.done && !tmr.load)
					next_state = osc_step;
			end
			ST_OSC: begin
				if (tmr.done && !tmr.load)
					next_state = flash_step;
			end
			ST_FLASH: begin
				if (tmr.done && !tmr.load)
					next_state = ST_SERVICE;
			end
			ST_SERVICE: next_state = ST_RUN;
			default:    next_state = ST_RUN;
		endcase
	end

	// Crystal waits count oscillator cycles, other waits system cycles
	assign tmr.tick_en = (state == ST_OSC) ? xtal_edge : 1'b1;

	// State register and timer loading on entry to a wait step
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state     <= ST_RUN;
			tmr.load  <= 1'b0;
			tmr.value <= '0;
		end else begin
			state    <= next_state;
			tmr.load <= (next_state != state) &&
				(next_state == ST_MVR || next_state == ST_OSC || next_state == ST_FLASH);
			case (next_state)
				ST_MVR:   tmr.value <= 16'(MVR_CYC);
				ST_OSC:   tmr.value <= settle;
				ST_FLASH: tmr.value <= 16'(FLASH_WAKE_CYC);
				default:  tmr.value <= tmr.value;
			endcase
		end
	end

	// Halt bookkeeping; a wake arriving in the halt entry cycle is lost to the wake_pend clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ah_mode   <= 1'b0;
			mvr_off   <= 1'b0;
			flash_off <= 1'b0;
			wake_pend <= 1'b0;
		end else if (state == ST_RUN && halt_req) begin
			ah_mode   <= active_halt;
			mvr_off   <= ctrl[CTRL_MVR_BIT];
			flash_off <= ctrl[CTRL_FLASH_BIT];
			wake_pend <= 1'b0;
		end else if (state == ST_HALT) begin
			wake_pend <= wake_pend || wake_evt;
		end
	end

	// Power and oscillator controls
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mvr_en   <= 1'b1;
			hsi_en   <= 1'b1;
			xtal_en  <= 1'b0;
			flash_pd <= 1'b0;
		end else if (state == ST_RUN && halt_req) begin
			mvr_en   <= !ctrl[CTRL_MVR_BIT];
			hsi_en   <= 1'b0;
			xtal_en  <= 1'b0;
			flash_pd <= ctrl[CTRL_FLASH_BIT];
		end else if (state == ST_HALT && next_state != ST_HALT) begin
			mvr_en  <= 1'b1;
			hsi_en  <= fast || src_req == SRC_HSI;
			xtal_en <= !fast && src_req == SRC_HSE;
		end else if (next_state == ST_FLASH || next_state == ST_SERVICE) begin
			flash_pd <= 1'b0;
		end
	end

	// CPU release and clock selection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cpu_run   <= 1'b1;
			vec_fetch <= 1'b0;
			clk_sel   <= SRC_HSI;
		end else begin
			vec_fetch <= (next_state == ST_SERVICE);
			if (next_state == ST_HALT || next_state == ST_WAIT)
				cpu_run <= 1'b0;
			else if (next_state == ST_SERVICE)
				cpu_run <= 1'b1;
			// Fast wakeup overrides the source until software rewrites it
			if (state == ST_HALT && next_state != ST_HALT)
				clk_sel <= fast ? SRC_HSI : src_req;
			else if (wr_fire && aw_addr == REG_CTRL && state == ST_RUN)
				clk_sel <= w_data[CTRL_SRC_LSB +: 2];
		end
	end

	// Prescalers and peripheral gates follow the register fields
	assign cpu_div = ctrl[CTRL_CDIV_LSB +: 3];
	assign hsi_div = ctrl[CTRL_HDIV_LSB +: 2];

	// Byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[8*b +: 8] = nw[8*b +: 8];
		return r;
	endfunction

	// Control and settle registers; ctrl output fields are flop bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl   <= CTRL_RST;
			settle <= SETTLE_RST;
		end else if (wr_fire) begin
			if (aw_addr == REG_CTRL)
				ctrl <= merge(ctrl, w_data, w_strb) & CTRL_MASK;
			if (aw_addr == REG_SETTLE)
				settle <= 16'(merge({16'h0000, settle}, w_data, w_strb));
		end
	end

	// Peripheral power and clock gate registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			periph_clk_en <= PCKEN_RST;
			periph_pwr_en <= PWR_RST;
		end else if (wr_fire && w_strb[0]) begin
			if (aw_addr == REG_PCKEN)
				periph_clk_en <= w_data[7:0];
			if (aw_addr == REG_PWR)
				periph_pwr_en <= w_data[7:0];
		end
	end

	// Write channels: address and data accepted in either order
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr       <= {s_axi_awaddr[7:2], 2'b00};
				aw_got        <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				w_got        <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				// Status is read-only; unmapped offsets answer with an error
				s_axi_bresp  <= (aw_addr <= REG_PWR) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_got        <= 1'b0;
				w_got         <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Read channel: one outstanding read, data from a register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'b00})
				REG_CTRL:   s_axi_rdata <= ctrl;
				REG_SETTLE: s_axi_rdata <= {16'h0000, settle};
				REG_PCKEN:  s_axi_rdata <= {24'h000000, periph_clk_en};
				REG_PWR:    s_axi_rdata <= {24'h000000, periph_pwr_en};
				REG_STATUS: s_axi_rdata <= {16'h0000, 6'h00, clk_sel, 1'b0, state,
					mvr_en, hsi_en, xtal_en, flash_pd};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule

//--- verilog/lpws_timer.sv
// Down-counter used for regulator, crystal and flash recovery waits.
// Assumes load is a one-cycle pulse from the sequencer.
`timescale 1ns/1ns
module lpws_timer
	import lpws_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	lpws_tmr_if.cnt   tmr
);
	logic [TMR_W-1:0] cnt;      // Remaining cycles

	// Load, then count down on each enabled cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= '0;
		end else if (tmr.load) begin
			cnt <= tmr.value;
		end else if (tmr.tick_en && cnt != '0) begin
			cnt <= cnt - 16'h0001;
		end
	end

	assign tmr.done = (cnt == '0);
endmodule

//--- verilog/lpws_tmr_if.sv
// Interface between the sequencer and its recovery-wait timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface lpws_tmr_if;
	logic             load;     // Load pulse
	logic [15:0]      value;    // Cycles to wait
	logic             tick_en;  // Count enable
	logic             done;     // Count has reached zero
	modport ctl (output load, output value, output tick_en, input done);
	modport cnt (input load, input value, input tick_en, output done);
endinterface
